//--- shared/synth_ctrl_pkg.sv
package synth_ctrl_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] FASTLOCK_WORD_OFFSET = 8'h00;
  localparam logic [7:0] RESET_LD_WORD_OFFSET = 8'h04;
  localparam logic [7:0] POWER_CTRL_OFFSET    = 8'h08;
  localparam logic [7:0] STATUS_OFFSET        = 8'h0C;

  localparam int WORD_W = 24;

  // Control nibble codes in bits 3..0
  localparam logic [3:0] FASTLOCK_NIBBLE = 4'hD;
  localparam logic [3:0] RESET_LD_NIBBLE = 4'hF;

  // Field positions
  localparam int SLIP_HI      = 23;
  localparam int SLIP_LO      = 22;
  localparam int PRESCALE_BIT = 13;
  localparam int AUX_CLR_BIT  = 7;
  localparam int MAIN_CLR_BIT = 6;
  localparam int AUX_FLT_BIT  = 5;
  localparam int MAIN_FLT_BIT = 4;

  // Fixed pattern of the reset and lock-detect word
  localparam logic [23:0] RESET_LD_FIXED_MASK  = 24'hFFDF0F;
  localparam logic [23:0] RESET_LD_FIXED_VALUE = 24'h00080F;

  localparam logic [23:0] FASTLOCK_RESET   = 24'h00000D;
  localparam logic [23:0] RESET_LD_RESET   = 24'h00080F;

  // Sample-rate reduction: divider terminal count per select code
  localparam logic [1:0] SLIP_OFF  = 2'h0;
  localparam logic [1:0] SLIP_HALF = 2'h1;
  localparam logic [1:0] SLIP_QTR  = 2'h2;
  localparam logic [1:0] SLIP_SIXT = 2'h3;
  localparam logic [3:0] DIV_BY_1  = 4'h0;
  localparam logic [3:0] DIV_BY_2  = 4'h1;
  localparam logic [3:0] DIV_BY_4  = 4'h3;
  localparam logic [3:0] DIV_BY_16 = 4'hF;
  localparam logic [3:0] LD_PRESCALE_MAX = 4'h3;

  // Cycles the automatic counter reset is held after power-up
  localparam logic [3:0] POWERUP_CLEAR_CYCLES = 4'h4;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- verilog/rate_divider.sv
`timescale 1ns/10ps
module rate_divider
  import synth_ctrl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic       tick_in,
  input  wire logic [3:0] terminal,
  output logic            tick_out
);
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic       wrap;
  logic       tick_next;

  assign wrap       = tick_in && (count_reg >= terminal);
  assign count_next = !enable ? 4'h0 : (wrap ? 4'h0 : (tick_in ? count_reg + 4'h1 : count_reg));
  assign tick_next  = enable && wrap;

  // Counter held cleared while disabled so restart is phase-aligned
  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg <= 4'h0;
      tick_out  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_out  <= tick_next;
    end
  end
endmodule

//--- verilog/synth_ctrl_bits.sv
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
// What this block and its host do
// R1: Slip select sets detector rate 1,1/2,1/4,1/16
// R2: Slip select sits in fastlock word bits 23:22
// R3: Control word fixed pattern bits enforced
// R4: Prescale bit13; clears/floats bits 7..4
// R5: Prescale divides main lock-detect rate by 4
// R6: Host sets prescale above 20 MHz comparison
// R7: Aux clear resets aux counters, floats pump
// R8: Main clear resets main counters, floats pump
// R9: Host keeps clear bits zero normally
// R10: Power-up applies automatic counter reset
// R11: Main float floats pump, counters run
// R12: Aux float floats pump, counters run
// R13: Fields hold until word rewritten
module synth_ctrl_bits
  import synth_ctrl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        chip_enable_pin,
  input  wire logic        main_compare_tick,
  input  wire logic        aux_compare_tick,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [1:0]       cycle_slip_reduction_sel,
  output logic             detector_sample_tick,
  output logic             main_lock_detect_tick,
  output logic             aux_lock_detect_tick,
  output logic             main_counter_hold,
  output logic             aux_counter_hold,
  output logic             main_pump_tristate,
  output logic             aux_pump_tristate
);
  logic [23:0] fastlock_reg;
  logic [23:0] fastlock_next;
  logic [23:0] reset_ld_reg;
  logic [23:0] reset_ld_next;
  logic        soft_power_reg;
  logic        soft_power_next;
  logic        pattern_err_reg;
  logic        pattern_err_next;
  logic        ce_meta_reg;
  logic        ce_sync_reg;
  logic        powered_reg;
  logic [3:0]  pu_count_reg;
  logic [3:0]  pu_count_next;
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;
  logic [31:0] hrdata_next;
  logic        main_ld_raw;
  logic        sample_raw;
  logic        main_clr_int;
  logic        aux_clr_int;

  function automatic logic [3:0] slip_terminal(input logic [1:0] sel);
    case (sel)
      SLIP_HALF: slip_terminal = DIV_BY_2;
      SLIP_QTR:  slip_terminal = DIV_BY_4;
      SLIP_SIXT: slip_terminal = DIV_BY_16;
      default:   slip_terminal = DIV_BY_1;
    endcase
  endfunction

  wire         addr_phase   = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire         wr_fastlock  = wr_pend_reg && (addr_reg == FASTLOCK_WORD_OFFSET) &&
                              (hwdata[3:0] == FASTLOCK_NIBBLE);                   // [R2]
  wire         wr_reset_ld  = wr_pend_reg && (addr_reg == RESET_LD_WORD_OFFSET) &&
                              (hwdata[3:0] == RESET_LD_NIBBLE);
  wire         pattern_ok   = (hwdata[23:0] & RESET_LD_FIXED_MASK) ==
                              RESET_LD_FIXED_VALUE;                                 // [R3]
  wire         wr_power     = wr_pend_reg && (addr_reg == POWER_CTRL_OFFSET);
  wire         powered_now  = soft_power_reg && ce_sync_reg;
  wire         power_rise   = powered_now && !powered_reg;
  wire         pu_clearing  = pu_count_reg != 4'h0;
  wire [1:0]   slip_field   = fastlock_reg[SLIP_HI:SLIP_LO];                        // [R2]
  wire         prescale_on  = reset_ld_reg[PRESCALE_BIT];                           // [R4]

  // Fixed-pattern violations are refused whole and flagged, never half-applied
  assign fastlock_next    = wr_fastlock ? hwdata[23:0] : fastlock_reg;              // [R13]
  assign reset_ld_next    = (wr_reset_ld && pattern_ok) ? hwdata[23:0]
                                                        : reset_ld_reg;             // [R13]
  assign soft_power_next  = wr_power ? hwdata[0] : soft_power_reg;
  assign pattern_err_next = (wr_reset_ld && !pattern_ok) ||
                            (pattern_err_reg && !(wr_pend_reg &&
                             (addr_reg == STATUS_OFFSET) && hwdata[0]));            // [R3]
  assign pu_count_next    = power_rise ? POWERUP_CLEAR_CYCLES :
                            (pu_clearing ? pu_count_reg - 4'h1 : 4'h0);             // [R10]

  assign main_clr_int = reset_ld_reg[MAIN_CLR_BIT] || pu_clearing;                   // [R8] [R10]
  assign aux_clr_int  = reset_ld_reg[AUX_CLR_BIT] || pu_clearing;                    // [R7] [R10]

  always_comb begin
    hrdata_next = 32'h0000_0000;
    case (addr_reg)
      FASTLOCK_WORD_OFFSET: hrdata_next = {8'h00, fastlock_reg};
      POWER_CTRL_OFFSET:    hrdata_next = {31'h0, soft_power_reg};
      STATUS_OFFSET:        hrdata_next = {26'h0, pattern_err_reg, pu_clearing,
                                           ce_sync_reg, powered_now,
                                           slip_field};
      default:              hrdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      rd_pend_reg <= addr_phase && !hwrite;
      if (addr_phase) begin
        addr_reg <= haddr[7:0];
      end
      hrdata      <= hrdata_next;
      // One wait state on reads: hrdata is registered from the captured address
      hreadyout   <= !(addr_phase && !hwrite);
      hresp       <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      fastlock_reg    <= FASTLOCK_RESET;
      reset_ld_reg    <= RESET_LD_RESET;
      soft_power_reg  <= 1'b1;
      pattern_err_reg <= 1'b0;
      ce_meta_reg     <= 1'b0;
      ce_sync_reg     <= 1'b0;
      powered_reg     <= 1'b0;
      pu_count_reg    <= 4'h0;
    end else begin
      fastlock_reg    <= fastlock_next;
      reset_ld_reg    <= reset_ld_next;
      soft_power_reg  <= soft_power_next;
      pattern_err_reg <= pattern_err_next;
      ce_meta_reg     <= chip_enable_pin;
      ce_sync_reg     <= ce_meta_reg;
      powered_reg     <= powered_now;
      pu_count_reg    <= pu_count_next;
    end
  end

  // Dividers cleared while main counters held, so ticks restart phase-aligned
  rate_divider u_sample_div (
    .clock    (clock),
    .reset    (reset),
    .enable   (!main_clr_int),
    .tick_in  (main_compare_tick),
    .terminal (slip_terminal(slip_field)),                                          // [R1]
    .tick_out (sample_raw)
  );

  rate_divider u_ld_div (
    .clock    (clock),
    .reset    (reset),
    .enable   (!main_clr_int),
    .tick_in  (main_compare_tick),
    .terminal (prescale_on ? LD_PRESCALE_MAX : DIV_BY_1),                           // [R5]
    .tick_out (main_ld_raw)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      cycle_slip_reduction_sel <= SLIP_OFF;
      detector_sample_tick     <= 1'b0;
      main_lock_detect_tick    <= 1'b0;
      aux_lock_detect_tick     <= 1'b0;
      main_counter_hold        <= 1'b0;
      aux_counter_hold         <= 1'b0;
      main_pump_tristate       <= 1'b0;
      aux_pump_tristate        <= 1'b0;
    end else begin
      cycle_slip_reduction_sel <= slip_field;                                       // [R1]
      detector_sample_tick     <= sample_raw;                                       // [R1]
      main_lock_detect_tick    <= main_ld_raw;                                      // [R5]
      // Aux comparison rate never prescaled
      aux_lock_detect_tick     <= aux_compare_tick && !aux_clr_int;                 // [R5]
      main_counter_hold        <= main_clr_int;                                     // [R8]
      aux_counter_hold         <= aux_clr_int;                                      // [R7]
      main_pump_tristate       <= main_clr_int || reset_ld_reg[MAIN_FLT_BIT];       // [R11]
      aux_pump_tristate        <= aux_clr_int || reset_ld_reg[AUX_FLT_BIT];         // [R12]
    end
  end
endmodule

//--- tb/synth_ctrl_bits_asserts.sv
`timescale 1ns/10ps
module synth_ctrl_bits_asserts (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       main_compare_tick,
  input wire logic       aux_compare_tick,
  input wire logic [1:0] cycle_slip_reduction_sel,
  input wire logic       detector_sample_tick,
  input wire logic       main_lock_detect_tick,
  input wire logic       aux_lock_detect_tick,
  input wire logic       main_counter_hold,
  input wire logic       aux_counter_hold,
  input wire logic       main_pump_tristate,
  input wire logic       aux_pump_tristate
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_main_hold_float: assert property (main_counter_hold |-> main_pump_tristate)
    else $error("main hold without pump float");
  a_aux_hold_float: assert property (aux_counter_hold |-> aux_pump_tristate)
    else $error("aux hold without pump float");
  a_aux_tick_cause: assert property (aux_lock_detect_tick |-> $past(aux_compare_tick))
    else $error("aux lock tick without aux tick");
  a_main_ld_cause: assert property (main_lock_detect_tick |-> $past(main_compare_tick, 2))
    else $error("main lock tick without main tick");
  a_sample_cause: assert property (detector_sample_tick |-> $past(main_compare_tick, 2))
    else $error("sample tick without main tick");
  a_full_rate: assert property (main_compare_tick && cycle_slip_reduction_sel == 2'h0
    && !main_counter_hold ##1 !main_counter_hold |=> detector_sample_tick)
    else $error("sample tick missing at full rate");
  a_clear_min_len: assert property ($rose(main_counter_hold) |-> main_counter_hold[*4])
    else $error("main counter hold too short");
  a_float_release: assert property ($fell(main_pump_tristate) |-> !main_counter_hold)
    else $error("pump float dropped while held");
  cover property (detector_sample_tick && cycle_slip_reduction_sel == 2'h3);
  cover property (main_pump_tristate && !main_counter_hold);
  cover property (aux_pump_tristate && !aux_counter_hold);
endmodule
bind synth_ctrl_bits synth_ctrl_bits_asserts i_synth_ctrl_bits_asserts (.*);

//--- tb/host_model.sv
`timescale 1ns/10ps
module host_model (
  input  wire logic        clock,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel = 1'b0,
  output logic [31:0]      haddr = 32'h0,
  output logic [1:0]       htrans = 2'h0,
  output logic             hwrite = 1'b0,
  output logic [2:0]       hsize = 3'h2,
  output logic [31:0]      hwdata = 32'h0
);
  // Single word transfers; hsel stays up, IDLE cycles are ignored by the slave
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
    // Released lines must not keep showing the old value
    haddr <= ~haddr;
    hwdata <= ~d;
  endtask
endmodule

//--- tb/synth_ctrl_bits_bench.sv
`timescale 1ns/10ps
module synth_ctrl_bits_bench;
  import synth_ctrl_pkg::*;
  logic        clock = 0, reset = 1, chip_enable_pin = 1, tick_en = 0;
  logic        main_compare_tick = 0, aux_compare_tick = 0, hsel, hwrite, hreadyout, hresp;
  logic        detector_sample_tick, main_lock_detect_tick, aux_lock_detect_tick;
  logic        main_counter_hold, aux_counter_hold, main_pump_tristate, aux_pump_tristate;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, cycle_slip_reduction_sel;
  logic [2:0]  hsize;
  wire         hready = hreadyout;
  int          fail_count = 0, checks = 0, n_ds = 0, n_ml = 0, n_al = 0, ds, ml, al;
  synth_ctrl_bits i_synth_ctrl_bits (.*);
  host_model i_host_model (.*);
  always #5 clock = ~clock;
  always @(posedge clock) begin
    main_compare_tick <= tick_en & ~main_compare_tick;
    aux_compare_tick <= tick_en & ~main_compare_tick;
    n_ds <= n_ds + detector_sample_tick;
    n_ml <= n_ml + main_lock_detect_tick;
    n_al <= n_al + aux_lock_detect_tick;
  end
  task automatic step;
    @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host_model.xfer(1'b1, a, d, rd);
    repeat (2) step;
  endtask
  // 64 main and aux ticks in a window padded on both sides
  task automatic measure;
    int b_ds, b_ml, b_al;
    @(posedge clock) tick_en <= 1'b0;
    repeat (4) step;
    b_ds = n_ds;
    b_ml = n_ml;
    b_al = n_al;
    @(posedge clock) tick_en <= 1'b1;
    repeat (127) step;
    @(posedge clock) tick_en <= 1'b0;
    repeat (4) step;
    ds = n_ds - b_ds;
    ml = n_ml - b_ml;
    al = n_al - b_al;
  endtask
  task automatic t_slip;
    for (int i = 0; i < 4; i++) begin
      wr(FASTLOCK_WORD_OFFSET, {8'h0, i[1:0], 18'h0, FASTLOCK_NIBBLE});
      check(cycle_slip_reduction_sel, i);
      i_host_model.xfer(1'b0, FASTLOCK_WORD_OFFSET, 32'h0, rd);
      check(rd, {8'h0, i[1:0], 18'h0, 4'hD});
      measure;
      check(ds, 32'h40 >> ((i == 3) ? 4 : i));
    end
    $display("slip select test done");
  endtask
  task automatic t_refuse;
    wr(RESET_LD_WORD_OFFSET, 32'h0000484F);
    wr(RESET_LD_WORD_OFFSET, 32'h0000084E);
    check({main_counter_hold, main_pump_tristate}, 2'h0);
    i_host_model.xfer(1'b0, STATUS_OFFSET, 32'h0, rd);
    check(rd[5], 1'b1);
    wr(FASTLOCK_WORD_OFFSET, 32'h0000000E);
    check(cycle_slip_reduction_sel, 2'h3);
    i_host_model.xfer(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    check({31'h0, hresp}, 32'h0);
    $display("refused write test done");
  endtask
  task automatic t_prescale;
    wr(RESET_LD_WORD_OFFSET, 32'h0000280F);
    measure;
    check(ml, 32'h10);
    check(al, 32'h40);
    wr(RESET_LD_WORD_OFFSET, 32'h0000080F);
    measure;
    check(ml, 32'h40);
    $display("prescale test done");
  endtask
  task automatic t_clear;
    logic [3:0] exp [4] = '{4'h2, 4'h1, 4'hA, 4'h5};
    for (int i = 0; i < 4; i++) begin
      wr(RESET_LD_WORD_OFFSET, 32'h0000080F | (32'h10 << i));
      check({main_counter_hold, aux_counter_hold, main_pump_tristate, aux_pump_tristate},
            exp[i]);
      if (i == 0) begin
        measure;
        check(ml, 32'h40);
      end
    end
    wr(RESET_LD_WORD_OFFSET, 32'h0000080F);
    check({main_counter_hold, aux_counter_hold}, 2'h0);
    $display("clear and float test done");
  endtask
  task automatic t_power;
    int n = 0;
    @(posedge clock) chip_enable_pin <= 1'b0;
    repeat (6) step;
    @(posedge clock) chip_enable_pin <= 1'b1;
    for (int w = 0; w < 20 && main_counter_hold !== 1'b1; w++) step;
    check({aux_counter_hold, aux_pump_tristate, main_pump_tristate}, 3'h7);
    while (main_counter_hold === 1'b1 && n < 20) begin
      n++;
      step;
    end
    check(n, {28'h0, POWERUP_CLEAR_CYCLES});
    $display("power-up clear test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (20) step;
    t_slip;
    t_refuse;
    t_prescale;
    t_clear;
    t_power;
    stop_test;
  end
endmodule
